// file: hdl/swp_pkg.sv
package swp_pkg;

	localparam int unsigned SLOTS     = 16;
	localparam int unsigned OTP_WORDS = 16;

	// Register byte offsets
	localparam logic [11:0] OFF_CMD        = 12'h000;
	localparam logic [11:0] OFF_STATUS     = 12'h004;
	localparam logic [11:0] OFF_WDATA      = 12'h008;
	localparam logic [11:0] OFF_RDATA      = 12'h00c;
	localparam logic [11:0] OFF_LOCKS      = 12'h010;
	localparam logic [11:0] OFF_SHA_FIX    = 12'h014;
	localparam logic [11:0] OFF_SHA_DIE_LO = 12'h018;
	localparam logic [11:0] OFF_SHA_DIE_HI = 12'h01c;
	localparam logic [11:0] OFF_SLOT_BASE  = 12'h040;
	localparam logic [11:0] OFF_FIXED_BASE = 12'h080;
	localparam int unsigned FIXED_WORDS    = 4;
	localparam int unsigned FIXED_BYTES    = 13;

	// Lock and mode byte values
	localparam logic [7:0] UNLOCKED     = 8'h55;
	localparam logic [7:0] MODE_RO      = 8'haa;
	localparam logic [7:0] MODE_CONSUME = 8'h55;
	localparam logic [7:0] MODE_LEGACY  = 8'h00;

	// Reset values
	localparam logic [7:0]  DATA_LOCK_RST = 8'h55;
	localparam logic [7:0]  CFG_LOCK_RST  = 8'h55;
	localparam logic [7:0]  OTP_MODE_RST  = 8'haa;
	localparam logic [15:0] SLOT_CFG_RST  = 16'h0000;
	localparam logic [31:0] OTP_WORD_RST  = 32'hffff_ffff;

	// Slot configuration fields
	localparam int unsigned WP_HI      = 15;
	localparam int unsigned WP_LO      = 12;
	localparam int unsigned AUTH_HI    = 11;
	localparam int unsigned AUTH_LO    = 8;
	localparam int unsigned SECRET_BIT = 7;

	// Lock register fields
	localparam int unsigned LK_DATA_LO = 0;
	localparam int unsigned LK_CFG_LO  = 8;
	localparam int unsigned LK_MODE_LO = 16;

	// Status register fields
	localparam int unsigned ST_DONE   = 0;
	localparam int unsigned ST_ERR    = 1;
	localparam int unsigned ST_MAC    = 2;
	localparam int unsigned ST_PARENT = 3;
	localparam int unsigned ST_SELF   = 4;
	localparam int unsigned ST_AND    = 5;
	localparam int unsigned ST_BUSY   = 6;
	localparam int unsigned ST_SRC_LO = 8;

	localparam logic [3:0] LEGACY_MIN_WORD = 4'h2;

	typedef enum logic [2:0] {
		OP_DERIVE  = 3'b000,
		OP_WR_SLOT = 3'b001,
		OP_RD_SLOT = 3'b010,
		OP_WR_OTP  = 3'b011,
		OP_RD_OTP  = 3'b100
	} swp_op_t;

	typedef struct packed {
		logic       die_req;
		logic       mac_ok;
		logic       len32;
		logic [3:0] idx;
		swp_op_t    op;
	} swp_cmd_t;

	typedef struct packed {
		logic       err;
		logic       need_mac;
		logic       parent;
		logic       self_key;
		logic [3:0] src;
	} swp_verdict_t;

	typedef enum logic [0:0] {
		EV_IDLE = 1'b0,
		EV_EXEC = 1'b1
	} swp_ev_t;

endpackage : swp_pkg

// file: hdl/swp_slot_policy.sv
`timescale 1ns/10ps
`default_nettype none
module swp_slot_policy (
	input  wire swp_pkg::swp_cmd_t  cmd,
	input  wire logic [15:0]        slot_cfg,
	input  wire logic               cfg_locked,
	input  wire logic               data_locked,
	output swp_pkg::swp_verdict_t   verdict
);
	logic [3:0] wp;
	logic [3:0] auth;
	logic       secret;

	// Bit 3 of wp is slot bit 15, bit 0 is slot bit 12
	assign wp     = slot_cfg[swp_pkg::WP_HI:swp_pkg::WP_LO];
	assign auth   = slot_cfg[swp_pkg::AUTH_HI:swp_pkg::AUTH_LO];
	assign secret = slot_cfg[swp_pkg::SECRET_BIT];

	always_comb begin
		verdict = '0;
		verdict.src = cmd.idx;
		case (cmd.op)
			swp_pkg::OP_DERIVE: begin
				// Derive view of the code, independent of the write view
				verdict.need_mac = wp[3];
				verdict.parent   = wp[0];
				verdict.src      = wp[0] ? auth : cmd.idx;
				verdict.err      = ~cfg_locked | ~wp[1] | (wp[3] & ~cmd.mac_ok);
			end
			swp_pkg::OP_WR_SLOT: begin
				if (!cfg_locked) begin
					verdict.err = 1'b1;
				end else if (!data_locked) begin
					verdict.err = 1'b0;
				end else if (wp[2]) begin
					verdict.need_mac = 1'b1;
					verdict.src      = auth;
					verdict.self_key = (auth == cmd.idx);
					verdict.err      = ~cmd.len32 | ~cmd.mac_ok;
				end else if (wp[3] || wp[1]) begin
					verdict.err = 1'b1;
				end else begin
					verdict.err = 1'b0;
				end
				if (secret && !cmd.len32) begin
					verdict.err = 1'b1;
				end
			end
			swp_pkg::OP_RD_SLOT: begin
				verdict.err = ~cfg_locked | ~data_locked | (secret & ~cmd.len32);
			end
			default: begin
				verdict.err = 1'b1;
			end
		endcase
	end
endmodule : swp_slot_policy
`default_nettype wire

// file: hdl/swp_policy_top.sv
`timescale 1ns/10ps
`default_nettype none
// What this block does
// - Roll derive allowed; bit 15 demands MAC
// - Create derive uses parent key slot
// - Derive refused when policy bit 13 clear
// - Code 000 allows plain 4/32-byte writes
// - Never code refuses every write command once data is locked
// - Encrypt code needs MAC, refuses 4-byte writes once data is locked
// - Derive and write views decoded independently
// - Secret slots refuse any 4-byte access
// - Self-keyed encrypt write verified with current key
// - Config bytes 0-12 read-only, always readable
// - Serial bytes 0,1,8 always feed hash
// - Die bytes 2-7 feed hash on request
// - Four revision bytes freely readable
// - One-time zone closed until config locked
// - Before data lock: writes yes, reads no
// - Read-only mode: writes error, reads allowed
// - Consumption mode stores AND of old, new
// - Mode byte aa, 55, 00; others reserved
// - Legacy refuses words 0-1, 32-byte reads, writes
// - Policy in bits 15-12, key slot 11-8
// - Data lock byte 55 means unlocked
module swp_policy_top #(
	parameter logic [71:0] SERIAL   = 72'h99_8877_6655_4433_2211, // Arbitrary value
	parameter logic [31:0] REVISION = 32'h0a0b_0c0d                // Arbitrary value
) (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	input  wire logic [3:0]  pstrb,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	output logic [23:0]      sha_fixed_bits,
	output logic [47:0]      sha_die_bits,
	output logic             sha_die_en
);
	swp_pkg::swp_cmd_t     cmd_q;
	swp_pkg::swp_verdict_t slot_verdict;
	swp_pkg::swp_ev_t      ev_q;
	logic [15:0]           slot_cfg_q [swp_pkg::SLOTS];
	logic [31:0]           otp_q [swp_pkg::OTP_WORDS];
	logic [7:0]            data_lock_q;
	logic [7:0]            cfg_lock_q;
	logic [7:0]            otp_mode_q;
	logic [31:0]           wdata_q;
	logic [31:0]           rdata_q;
	logic [31:0]           status_q;
	logic [31:0]           prdata_q;
	logic [47:0]           die_q;
	logic                  die_en_q;
	logic                  cfg_locked;
	logic                  data_locked;
	logic                  setup;
	logic                  access;
	logic                  wr_fire;
	logic [31:0]           rd_val;
	logic                  rd_hit;
	logic                  wr_bad;
	logic                  is_slot;
	logic                  is_fixed;
	logic [3:0]            slot_sel;
	logic                  otp_err;
	logic                  otp_and;
	logic                  op_err;

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
	                                      input logic [3:0] strb);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				r[i*8 +: 8] = nw[i*8 +: 8];
			end
		end
		return r;
	endfunction : merge

	function automatic logic [7:0] serial_byte(input int unsigned n);
		return SERIAL[n*8 +: 8];
	endfunction : serial_byte

	// Bytes 0-3 serial, 4-7 revision, 8-12 serial; above byte 12 reads zero
	function automatic logic [7:0] fixed_byte(input int unsigned n);
		logic [7:0] b;
		b = 8'h00;
		if (n < 4) begin
			b = serial_byte(n);
		end else if (n < 8) begin
			b = REVISION[(n-4)*8 +: 8];
		end else if (n < swp_pkg::FIXED_BYTES) begin
			b = serial_byte(n - 4);
		end
		return b;
	endfunction : fixed_byte

	assign cfg_locked  = (cfg_lock_q != swp_pkg::UNLOCKED);
	assign data_locked = (data_lock_q != swp_pkg::UNLOCKED);

	assign setup    = psel & ~penable;
	assign access   = psel & penable;
	assign is_slot  = (paddr >= swp_pkg::OFF_SLOT_BASE) &&
	                  (paddr < swp_pkg::OFF_SLOT_BASE + 12'(swp_pkg::SLOTS * 4));
	assign is_fixed = (paddr >= swp_pkg::OFF_FIXED_BASE) &&
	                  (paddr < swp_pkg::OFF_FIXED_BASE + 12'(swp_pkg::FIXED_WORDS * 4));
	assign slot_sel = paddr[5:2];

	always_comb begin
		rd_val = 32'h0000_0000;
		rd_hit = 1'b1;
		if (is_slot) begin
			rd_val = {16'h0000, slot_cfg_q[slot_sel]};
		end else if (is_fixed) begin
			for (int i = 0; i < 4; i++) begin
				rd_val[i*8 +: 8] = fixed_byte(32'(paddr[3:2]) * 4 + 32'(i));
			end
		end else begin
			case (paddr)
				swp_pkg::OFF_CMD:        rd_val = 32'(cmd_q);
				swp_pkg::OFF_STATUS:     rd_val = status_q;
				swp_pkg::OFF_WDATA:      rd_val = wdata_q;
				swp_pkg::OFF_RDATA:      rd_val = rdata_q;
				swp_pkg::OFF_LOCKS:      rd_val = {8'h00, otp_mode_q, cfg_lock_q, data_lock_q};
				swp_pkg::OFF_SHA_FIX:    rd_val = {8'h00, sha_fixed_bits};
				swp_pkg::OFF_SHA_DIE_LO: rd_val = die_q[31:0];
				swp_pkg::OFF_SHA_DIE_HI: rd_val = {16'h0000, die_q[47:32]};
				default:                 rd_hit = 1'b0;
			endcase
		end
	end

	// Fixed bytes are never writable; config table only while config is open
	always_comb begin
		wr_bad = ~rd_hit;
		if (is_fixed) begin
			wr_bad = 1'b1;
		end else if (is_slot) begin
			wr_bad = cfg_locked;
		end else if (paddr == swp_pkg::OFF_STATUS || paddr == swp_pkg::OFF_RDATA ||
		             paddr == swp_pkg::OFF_SHA_FIX || paddr == swp_pkg::OFF_SHA_DIE_LO ||
		             paddr == swp_pkg::OFF_SHA_DIE_HI) begin
			wr_bad = 1'b1;
		end else if (paddr == swp_pkg::OFF_CMD) begin
			wr_bad = (ev_q != swp_pkg::EV_IDLE);
		end
	end

	assign pready  = 1'b1;
	assign pslverr = access & (pwrite ? wr_bad : ~rd_hit);
	assign wr_fire = access & pwrite & ~wr_bad;
	assign prdata  = prdata_q;

	// Read data is fetched in the setup cycle so it leaves a flop
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_q <= 32'h0000_0000;
		end else if (setup && !pwrite) begin
			prdata_q <= rd_hit ? rd_val : 32'h0000_0000;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int i = 0; i < swp_pkg::SLOTS; i++) begin
				slot_cfg_q[i] <= swp_pkg::SLOT_CFG_RST;
			end
		end else if (wr_fire && is_slot) begin
			slot_cfg_q[slot_sel] <= 16'(merge({16'h0000, slot_cfg_q[slot_sel]}, pwdata, pstrb));
		end
	end

	// A lock byte never returns to the open value once closed
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			data_lock_q <= swp_pkg::DATA_LOCK_RST;
			cfg_lock_q  <= swp_pkg::CFG_LOCK_RST;
			otp_mode_q  <= swp_pkg::OTP_MODE_RST;
		end else if (wr_fire && paddr == swp_pkg::OFF_LOCKS) begin
			if (pstrb[0] && !data_locked) begin
				data_lock_q <= pwdata[swp_pkg::LK_DATA_LO +: 8];
			end
			if (pstrb[1] && !cfg_locked) begin
				cfg_lock_q <= pwdata[swp_pkg::LK_CFG_LO +: 8];
			end
			if (pstrb[2] && !cfg_locked) begin
				otp_mode_q <= pwdata[swp_pkg::LK_MODE_LO +: 8];
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wdata_q <= 32'h0000_0000;
		end else if (wr_fire && paddr == swp_pkg::OFF_WDATA) begin
			wdata_q <= merge(wdata_q, pwdata, pstrb);
		end
	end

	// Command capture and one evaluation cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cmd_q <= '0;
			ev_q  <= swp_pkg::EV_IDLE;
		end else begin
			case (ev_q)
				swp_pkg::EV_IDLE: begin
					if (wr_fire && paddr == swp_pkg::OFF_CMD) begin
						cmd_q <= swp_pkg::swp_cmd_t'(pwdata[$bits(swp_pkg::swp_cmd_t)-1:0]);
						ev_q  <= swp_pkg::EV_EXEC;
					end
				end
				swp_pkg::EV_EXEC: ev_q <= swp_pkg::EV_IDLE;
				default:          ev_q <= swp_pkg::EV_IDLE;
			endcase
		end
	end

	swp_slot_policy u_slot_policy (
		.cmd         (cmd_q),
		.slot_cfg    (slot_cfg_q[cmd_q.idx]),
		.cfg_locked  (cfg_locked),
		.data_locked (data_locked),
		.verdict     (slot_verdict)
	);

	// One-time zone permissions by lock state and mode
	always_comb begin
		otp_err = 1'b1;
		otp_and = 1'b0;
		if (!cfg_locked) begin
			otp_err = 1'b1;
		end else if (!data_locked) begin
			otp_err = (cmd_q.op != swp_pkg::OP_WR_OTP);
		end else begin
			case (otp_mode_q)
				swp_pkg::MODE_RO: begin
					otp_err = (cmd_q.op == swp_pkg::OP_WR_OTP);
				end
				swp_pkg::MODE_CONSUME: begin
					otp_err = 1'b0;
					otp_and = (cmd_q.op == swp_pkg::OP_WR_OTP);
				end
				swp_pkg::MODE_LEGACY: begin
					otp_err = (cmd_q.op == swp_pkg::OP_WR_OTP) || cmd_q.len32 ||
					          (cmd_q.idx < swp_pkg::LEGACY_MIN_WORD);
				end
				default: otp_err = 1'b1;
			endcase
		end
	end

	assign op_err = (cmd_q.op == swp_pkg::OP_WR_OTP || cmd_q.op == swp_pkg::OP_RD_OTP) ?
	                otp_err : slot_verdict.err;

	// Refused commands leave storage alone; only status reports them
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int i = 0; i < swp_pkg::OTP_WORDS; i++) begin
				otp_q[i] <= swp_pkg::OTP_WORD_RST;
			end
		end else if (ev_q == swp_pkg::EV_EXEC && !op_err && cmd_q.op == swp_pkg::OP_WR_OTP) begin
			otp_q[cmd_q.idx] <= otp_and ? (otp_q[cmd_q.idx] & wdata_q) : wdata_q;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rdata_q <= 32'h0000_0000;
		end else if (ev_q == swp_pkg::EV_EXEC && !op_err && cmd_q.op == swp_pkg::OP_RD_OTP) begin
			rdata_q <= otp_q[cmd_q.idx];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			status_q <= 32'h0000_0000;
		end else if (ev_q == swp_pkg::EV_EXEC) begin
			status_q                              <= 32'h0000_0000;
			status_q[swp_pkg::ST_DONE]            <= 1'b1;
			status_q[swp_pkg::ST_ERR]             <= op_err;
			status_q[swp_pkg::ST_MAC]             <= slot_verdict.need_mac & ~op_err;
			status_q[swp_pkg::ST_PARENT]          <= slot_verdict.parent & ~op_err;
			status_q[swp_pkg::ST_SELF]            <= slot_verdict.self_key & ~op_err;
			status_q[swp_pkg::ST_AND]             <= otp_and & ~op_err;
			status_q[swp_pkg::ST_SRC_LO +: 4]     <= slot_verdict.src;
		end else if (wr_fire && paddr == swp_pkg::OFF_CMD) begin
			status_q                   <= 32'h0000_0000;
			status_q[swp_pkg::ST_BUSY] <= 1'b1;
		end
	end

	// Die bytes join the hash only for commands that ask for them
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			die_q    <= 48'h0000_0000_0000;
			die_en_q <= 1'b0;
		end else if (ev_q == swp_pkg::EV_EXEC) begin
			die_en_q <= cmd_q.die_req & ~op_err;
			die_q    <= (cmd_q.die_req && !op_err) ? SERIAL[63:16] : 48'h0000_0000_0000;
		end
	end

	assign sha_fixed_bits = {serial_byte(8), serial_byte(1), serial_byte(0)};
	assign sha_die_bits   = die_q;
	assign sha_die_en     = die_en_q;

endmodule : swp_policy_top
`default_nettype wire

// file: verification/swp_policy_asserts.sv
`timescale 1ns/10ps
`default_nettype none
module swp_policy_asserts #(
	parameter logic [71:0] SERIAL = 72'h0
) (
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic [23:0] sha_fixed_bits,
	input wire logic [47:0] sha_die_bits,
	input wire logic        sha_die_en
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	wire logic acc = psel && penable;
	wire logic fix = paddr[11:4] == 8'h08;
	chk_zero_wait: assert property (acc |-> pready)
		else $error("wait state seen");
	chk_err_idle: assert property (!acc |-> !pslverr)
		else $error("error outside access");
	chk_fixed_serial: assert property (sha_fixed_bits == {SERIAL[71:64], SERIAL[15:0]})
		else $error("fixed hash bits wrong");
	chk_die_value: assert property (sha_die_bits == (sha_die_en ? SERIAL[63:16] : 48'h0))
		else $error("die bits wrong");
	chk_die_timing: assert property ($changed(sha_die_en) |->
		$past(acc && pwrite && paddr == swp_pkg::OFF_CMD, 2)) else $error("die enable moved");
	chk_fixed_nowrite: assert property (acc && pwrite && fix |-> pslverr)
		else $error("fixed write accepted");
	chk_fixed_read: assert property (acc && !pwrite && fix |-> !pslverr)
		else $error("fixed read refused");
	chk_unmapped_err: assert property (acc && paddr[11:8] != 4'h0 |-> pslverr)
		else $error("unmapped accepted");
	chk_status_ro: assert property (acc && pwrite && paddr == swp_pkg::OFF_STATUS |->
		pslverr) else $error("status write accepted");
	chk_rdata_hold: assert property ($changed(prdata) |-> $past(psel && !penable && !pwrite))
		else $error("read data moved");
	cover property ($rose(sha_die_en));
	cover property (acc && pslverr);
	cover property (acc && pwrite && paddr == swp_pkg::OFF_CMD);
endmodule : swp_policy_asserts
bind swp_policy_top swp_policy_asserts #(.SERIAL(SERIAL)) chk_u (.pclk(pclk), .presetn(presetn),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .sha_fixed_bits(sha_fixed_bits),
	.sha_die_bits(sha_die_bits), .sha_die_en(sha_die_en));
`default_nettype wire

// file: verification/swp_host.sv
`timescale 1ns/10ps
`default_nettype none
module swp_host (
	input  wire logic        pclk,
	input  wire logic [31:0] prdata,
	input  wire logic        pready,
	input  wire logic        pslverr,
	output logic             psel,
	output logic             penable,
	output logic             pwrite,
	output logic [11:0]      paddr,
	output logic [31:0]      pwdata,
	output logic [3:0]       pstrb
);
	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
		pstrb = 4'h0;
	end
	// Request held until pready is seen, so wait states stay legal
	task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
		input logic [3:0] s, output logic [31:0] r, output logic e);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		pstrb <= s;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : xfer
	// MAC verdict travels in the command word
	task automatic cmd(input swp_pkg::swp_cmd_t c, output logic [31:0] st);
		logic e;
		xfer(1'b1, swp_pkg::OFF_CMD, {22'h0, c}, 4'hf, st, e);
		st = 32'h0;
		for (int i = 0; i < 16 && st[swp_pkg::ST_DONE] !== 1'b1; i++) begin
			xfer(1'b0, swp_pkg::OFF_STATUS, 32'h0, 4'h0, st, e);
		end
	endtask : cmd
endmodule : swp_host
`default_nettype wire

// file: verification/testbench.sv
`timescale 1ns/10ps
`default_nettype none
`define SWP_CHK(a, e) chk_val(32'(a), 32'(e))
module testbench;
	localparam logic [71:0] SERIAL = 72'h99_8877_6655_4433_2211; // Arbitrary value
	localparam logic [31:0] REV    = 32'h0a0b_0c0d;              // Arbitrary value
	localparam logic [31:0] FIX [4] = '{SERIAL[31:0], REV, SERIAL[63:32], {24'h0, SERIAL[71:64]}};
	localparam logic [15:0] CFG [9] = '{16'h0000, 16'h2080, 16'ha080, 16'h3580, 16'hb680,
		16'h6580, 16'h4980, 16'h8080, 16'h0080};
	localparam logic [6:0] DER [9] = '{7'h01, 7'h08, 7'h12, 7'h2c, 7'h36, 7'h28, 7'h01,
		7'h01, 7'h01};
	localparam logic [2:0] WRX [9] = '{3'b000, 3'b101, 3'b101, 3'b101, 3'b101, 3'b110,
		3'b101, 3'b101, 3'b001};
	logic        pclk;
	logic        presetn;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [11:0] paddr;
	logic [31:0] pwdata;
	logic [3:0]  pstrb;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic [23:0] sha_fixed_bits;
	logic [47:0] sha_die_bits;
	logic        sha_die_en;
	int          err_count;
	int          cmp_count;
	always #50 pclk = ~pclk;
	swp_policy_top #(.SERIAL(SERIAL), .REVISION(REV)) dut_u (.pclk(pclk),
		.presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.sha_fixed_bits(sha_fixed_bits), .sha_die_bits(sha_die_bits), .sha_die_en(sha_die_en));
	swp_host host_u (.pclk(pclk), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.pstrb(pstrb));
	task automatic chk_val(input logic [31:0] a, input logic [31:0] e);
		cmp_count++;
		if (a !== e) begin
			err_count++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, a, e);
		end
	endtask : chk_val
	task automatic test_done();
		$display("errors=%0d compares=%0d", err_count, cmp_count);
		if (err_count == 0 && cmp_count > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : test_done
	task automatic do_reset();
		@(posedge pclk);
		presetn <= 1'b0;
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
	endtask : do_reset
	task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
		output logic e);
		logic [31:0] r;
		host_u.xfer(1'b1, a, d, s, r, e);
	endtask : wr
	task automatic rd(input logic [11:0] a, output logic [31:0] r, output logic e);
		host_u.xfer(1'b0, a, 32'h0, 4'h0, r, e);
	endtask : rd
	task automatic otp(input logic w, input logic [3:0] i, input logic len,
		input logic [31:0] d, output logic [31:0] st, output logic [31:0] r);
		logic e;
		wr(swp_pkg::OFF_WDATA, d, 4'hf, e);
		host_u.cmd('{1'b0, 1'b0, len, i, w ? swp_pkg::OP_WR_OTP : swp_pkg::OP_RD_OTP}, st);
		rd(swp_pkg::OFF_RDATA, r, e);
	endtask : otp
	task automatic t_reset();
		logic [31:0] r;
		logic [31:0] st;
		logic        e;
		rd(swp_pkg::OFF_LOCKS, r, e);
		`SWP_CHK(r, 32'h00aa_5555);
		rd(12'h020, r, e);
		`SWP_CHK(e, 1'b1);
		`SWP_CHK(sha_fixed_bits, {SERIAL[71:64], SERIAL[15:0]});
		// Fixed window readable before any lock closes
		rd(swp_pkg::OFF_FIXED_BASE + 12'h004, r, e);
		`SWP_CHK(e, 1'b0);
		`SWP_CHK(r, REV);
		otp(1'b1, 4'h2, 1'b0, 32'h0, st, r);
		`SWP_CHK(st[1], 1'b1);
		otp(1'b0, 4'h2, 1'b0, 32'h0, st, r);
		`SWP_CHK(st[1], 1'b1);
	endtask : t_reset
	task automatic t_slots();
		logic [24:0] die_exp;
		logic [31:0] r;
		logic [31:0] st;
		logic        e;
		// Key slots 1-8 carry the secret flag; slot 0 does not
		for (int i = 0; i < 9; i++) begin
			wr(swp_pkg::OFF_SLOT_BASE + 12'(4 * i), {16'h0, CFG[i]}, 4'hf, e);
		end
		rd(swp_pkg::OFF_SLOT_BASE + 12'h014, r, e);
		`SWP_CHK(r, 32'h6580);
		wr(swp_pkg::OFF_LOCKS, 32'h0, 4'b0010, e);
		wr(swp_pkg::OFF_SLOT_BASE, 32'hffff, 4'hf, e);
		`SWP_CHK(e, 1'b1);
		wr(swp_pkg::OFF_LOCKS, 32'h0, 4'b0001, e);
		for (int i = 0; i < 9; i++) begin
			host_u.cmd('{1'(i == 1), 1'b1, 1'b0, 4'(i), swp_pkg::OP_DERIVE}, st);
			if (DER[i][0]) `SWP_CHK(st[1], 1'b1);
			else `SWP_CHK({st[11:8], st[3:1]}, DER[i]);
			die_exp = (i == 1) ? {1'b1, SERIAL[63:40]} : 25'h0;
			`SWP_CHK({sha_die_en, sha_die_bits[47:24]}, die_exp);
			host_u.cmd('{1'b0, WRX[i][1], WRX[i][2], 4'(i), swp_pkg::OP_WR_SLOT}, st);
			`SWP_CHK(st[1], WRX[i][0]);
		end
		host_u.cmd('{1'b0, 1'b1, 1'b1, 4'd5, swp_pkg::OP_WR_SLOT}, st);
		`SWP_CHK(st[4:1], 4'b1010);
		host_u.cmd('{1'b0, 1'b1, 1'b0, 4'd5, swp_pkg::OP_WR_SLOT}, st);
		`SWP_CHK(st[1], 1'b1);
		host_u.cmd('{1'b0, 1'b0, 1'b1, 4'd0, swp_pkg::OP_WR_SLOT}, st);
		`SWP_CHK(st[1], 1'b0);
		host_u.cmd('{1'b0, 1'b0, 1'b0, 4'd8, swp_pkg::OP_RD_SLOT}, st);
		`SWP_CHK(st[1], 1'b1);
		host_u.cmd('{1'b0, 1'b0, 1'b1, 4'd8, swp_pkg::OP_RD_SLOT}, st);
		`SWP_CHK(st[1], 1'b0);
		// Derive without a MAC verdict: refused only where bit 15 asks for one
		host_u.cmd('{1'b0, 1'b0, 1'b0, 4'd2, swp_pkg::OP_DERIVE}, st);
		`SWP_CHK(st[1], 1'b1);
		host_u.cmd('{1'b0, 1'b0, 1'b0, 4'd4, swp_pkg::OP_DERIVE}, st);
		`SWP_CHK(st[1], 1'b1);
		host_u.cmd('{1'b0, 1'b0, 1'b0, 4'd1, swp_pkg::OP_DERIVE}, st);
		`SWP_CHK(st[3:1], 3'b000);
		for (int k = 0; k < 4; k++) begin
			rd(swp_pkg::OFF_FIXED_BASE + 12'(4 * k), r, e);
			`SWP_CHK(e, 1'b0);
			`SWP_CHK(r, FIX[k]);
		end
		`SWP_CHK(r[31:8], 24'h0);
		wr(swp_pkg::OFF_FIXED_BASE, 32'h0, 4'hf, e);
		`SWP_CHK(e, 1'b1);
		wr(swp_pkg::OFF_STATUS, 32'h0, 4'hf, e);
		`SWP_CHK(e, 1'b1);
		rd(12'h100, r, e);
		`SWP_CHK(e, 1'b1);
	endtask : t_slots
	// Flags x: write refused, word 2 read refused, word 0 refused, 32-byte read refused
	task automatic t_otp_mode(input logic [7:0] m, input logic [3:0] x, input logic [31:0] v);
		logic [31:0] r;
		logic [31:0] st;
		logic        e;
		do_reset();
		wr(swp_pkg::OFF_LOCKS, {8'h0, m, 16'h0}, 4'b0100, e);
		wr(swp_pkg::OFF_LOCKS, 32'h0, 4'b0010, e);
		otp(1'b1, 4'h2, 1'b0, 32'h0f0f_00ff, st, r);
		`SWP_CHK(st[1], 1'b0);
		otp(1'b0, 4'h2, 1'b0, 32'h0, st, r);
		`SWP_CHK(st[1], 1'b1);
		wr(swp_pkg::OFF_LOCKS, 32'h0, 4'b0001, e);
		rd(swp_pkg::OFF_LOCKS, r, e);
		`SWP_CHK(r, {8'h0, m, 16'h0});
		otp(1'b1, 4'h2, 1'b1, 32'hff00_ff00, st, r);
		`SWP_CHK(st[1], x[3]);
		`SWP_CHK(st[5], m == swp_pkg::MODE_CONSUME);
		otp(1'b0, 4'h2, 1'b0, 32'h0, st, r);
		`SWP_CHK(st[1], x[2]);
		if (!x[2]) `SWP_CHK(r, v);
		otp(1'b0, 4'h0, 1'b0, 32'h0, st, r);
		`SWP_CHK(st[1], x[1]);
		otp(1'b0, 4'h2, 1'b1, 32'h0, st, r);
		`SWP_CHK(st[1], x[0]);
	endtask : t_otp_mode
	initial begin
		repeat (20000) @(posedge pclk);
		err_count++;
		test_done();
	end
	initial begin
		pclk = 1'b0;
		presetn = 1'b0;
		err_count = 0;
		cmp_count = 0;
		do_reset();
		t_reset();
		t_slots();
		t_otp_mode(8'haa, 4'b1000, 32'h0f0f_00ff);
		t_otp_mode(8'h55, 4'b0000, 32'h0f00_0000);
		t_otp_mode(8'h00, 4'b1011, 32'h0f0f_00ff);
		t_otp_mode(8'h3c, 4'b1111, 32'h0);
		test_done();
	end
endmodule : testbench
`default_nettype wire
